// ---- pkg/plk_defines.svh ----
// offsets, field positions, widths and reset values of the colour lookup
`ifndef PLK_DEFINES_SVH
`define PLK_DEFINES_SVH

`define PLK_ADDR_W 12
`define PLK_PAL_BASE 12'h000
`define PLK_PAL_LAST 12'h07c
`define PLK_CTL0_OFS 12'h100
`define PLK_CTL2_OFS 12'h104
`define PLK_STAT_OFS 12'h108

`define PLK_PAL_N 32
`define PLK_IDX_W 5
`define PLK_COL_W 12
`define PLK_PLANES 6

`define PLK_RED_HI 11
`define PLK_RED_LO 8
`define PLK_GRN_HI 7
`define PLK_GRN_LO 4
`define PLK_BLU_HI 3
`define PLK_BLU_LO 0

`define PLK_HIGH_RESOLUTION_ENABLE_BIT 15
`define PLK_CNT_HI 14
`define PLK_CNT_LO 12
`define PLK_HOLD_BIT 11
`define PLK_DUAL_BIT 10
`define PLK_PRI_BIT 6

`define PLK_CNT_FIVE 3'h5
`define PLK_CNT_SIX 3'h6
`define PLK_PF2_BASE 5'h08
`define PLK_BG_IDX 5'h00
`define PLK_COL_RST 12'h000
`define PLK_CTL0_RST 16'h0000
`define PLK_CTL2_RST 16'h0000
`define PLK_STAT_VALID_BIT 12

`endif

// ---- pkg/plk_pkg.sv ----
// types shared by the playfield colour lookup
`default_nettype none
package plk_pkg;
   typedef enum logic [1:0] {
      PLK_MODE_NORMAL,
      PLK_MODE_DUAL,
      PLK_MODE_HOLD
   } plk_mode_t;
   typedef enum logic [1:0] {
      PLK_HM_PALETTE,
      PLK_HM_BLUE,
      PLK_HM_RED,
      PLK_HM_GREEN
   } plk_hm_t;
endpackage
`default_nettype wire

// ---- rtl/plk_color_lookup.sv ----
// playfield colour lookup: palette, modes and apb register slave
//
// Behaviour
// - palette registers are write-only; reads return zero, never the stored colour.
// - each palette entry holds red 11:8, green 7:4, blue 3:0; 15:12 unused.
// - lowres single normal mode indexes entries 0-31 with planes 5..1.
// - lowres dual: field one planes 5,3,1 to 0-7; field two 6,4,2 to 8-15.
// - dual mode: field two code zero is transparent, not entry 8.
// - entry 0 supplies background wherever no field is opaque.
// - hold mode, planes 6,5 = 00: output entry indexed by planes 4..1.
// - hold mode, 01: keep held red and green, blue from planes 4..1.
// - hold mode, 10: keep held green and blue, red from planes 4..1.
// - hold mode, 11: keep held red and blue, green from planes 4..1.
// - high_resolution_enable single mode indexes entries 0-15 with planes 4..1.
// - high_resolution_enable dual: field one planes 3,1 to 0-3; field two 4,2 to 8-11.
// - hold mode only with hold on, dual off, high_resolution_enable off, five or six planes.
// - held colour is the colour output for the pixel to the left.
// - with five planes active the sixth plane bit reads as zero.
// - dual mode priority bit 1 puts field two in front, else field one.
`include "plk_defines.svh"
`default_nettype none

module plk_color_lookup (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`PLK_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [`PLK_PLANES-1:0] plane_bits,
   input wire logic pixel_valid,
   output logic [`PLK_COL_W-1:0] pixel_color,
   output logic pixel_color_valid,
   output plk_pkg::plk_mode_t active_mode
);
   import plk_pkg::*;

   // ************************************
   // address decode helpers
   // ************************************

   function automatic logic pal_hit(input logic [`PLK_ADDR_W-1:0] a);
      pal_hit = (a >= `PLK_PAL_BASE) && (a <= `PLK_PAL_LAST) && (a[1:0] == 2'b00);
   endfunction

   function automatic logic [`PLK_IDX_W-1:0] pal_idx(input logic [`PLK_ADDR_W-1:0] a);
      pal_idx = a[`PLK_IDX_W+1:2];
   endfunction

   function automatic logic ctl0_hit(input logic [`PLK_ADDR_W-1:0] a);
      ctl0_hit = (a == `PLK_CTL0_OFS);
   endfunction

   function automatic logic ctl2_hit(input logic [`PLK_ADDR_W-1:0] a);
      ctl2_hit = (a == `PLK_CTL2_OFS);
   endfunction

   function automatic logic stat_hit(input logic [`PLK_ADDR_W-1:0] a);
      stat_hit = (a == `PLK_STAT_OFS);
   endfunction

   function automatic logic reg_hit(input logic [`PLK_ADDR_W-1:0] a);
      reg_hit = pal_hit(a) || ctl0_hit(a) || ctl2_hit(a) || stat_hit(a);
   endfunction

   // ************************************
   // plane field codes
   // ************************************

   // five or six planes allow hold mode
   function automatic logic hold_depth(input logic [2:0] c);
      hold_depth = (c == `PLK_CNT_FIVE) || (c == `PLK_CNT_SIX);
   endfunction

   // low res field one, planes 5,3,1
   function automatic logic [2:0] lo_pf1(input logic [`PLK_PLANES-1:0] b);
      lo_pf1 = {b[4], b[2], b[0]};
   endfunction

   // low res field two, planes 6,4,2
   function automatic logic [2:0] lo_pf2(input logic [`PLK_PLANES-1:0] b);
      lo_pf2 = {b[5], b[3], b[1]};
   endfunction

   // high res field one, planes 3,1
   function automatic logic [1:0] hi_pf1(input logic [`PLK_PLANES-1:0] b);
      hi_pf1 = {b[2], b[0]};
   endfunction

   // high res field two, planes 4,2
   function automatic logic [1:0] hi_pf2(input logic [`PLK_PLANES-1:0] b);
      hi_pf2 = {b[3], b[1]};
   endfunction

   // ************************************
   // hold-and-modify helper
   // ************************************

   // held colour with one component replaced
   function automatic logic [`PLK_COL_W-1:0] hold_modify(input logic [`PLK_COL_W-1:0] held,
         input logic [3:0] v, input plk_hm_t hm);
      hold_modify = held;
      case (hm)
         PLK_HM_BLUE: begin
            hold_modify[`PLK_BLU_HI:`PLK_BLU_LO] = v;
         end
         PLK_HM_RED: begin
            hold_modify[`PLK_RED_HI:`PLK_RED_LO] = v;
         end
         PLK_HM_GREEN: begin
            hold_modify[`PLK_GRN_HI:`PLK_GRN_LO] = v;
         end
         default: begin
            hold_modify = held;
         end
      endcase
   endfunction

   // ************************************
   // state
   // ************************************

   logic [`PLK_COL_W-1:0] pal_r [`PLK_PAL_N];
   logic [15:0] ctl0_r;
   logic [15:0] ctl2_r;
   logic [`PLK_COL_W-1:0] color_r;
   logic [`PLK_COL_W-1:0] color_nxt;
   logic color_valid_r;
   logic wr_en;
   logic rd_en;
   logic pal_wr;
   logic ctl0_wr;
   logic ctl2_wr;
   logic [`PLK_PLANES-1:0] plane_mask;
   logic [`PLK_PLANES-1:0] p;
   logic high_resolution_enable;
   logic dual;
   logic hold_on;
   logic [2:0] plane_cnt;
   logic pf2_front;
   plk_mode_t mode;

   // ************************************
   // apb slave
   // ************************************

   // zero wait states
   assign pready = 1'b1;

   assign wr_en = psel && penable && pwrite && pready;
   assign rd_en = psel && penable && !pwrite && pready;

   assign pal_wr = wr_en && pal_hit(paddr);
   assign ctl0_wr = wr_en && ctl0_hit(paddr);
   assign ctl2_wr = wr_en && ctl2_hit(paddr);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < `PLK_PAL_N; i++) begin
            pal_r[i] <= `PLK_COL_RST;
         end
      end else if (pal_wr) begin
         pal_r[pal_idx(paddr)] <= pwdata[`PLK_COL_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl0_r <= `PLK_CTL0_RST;
      end else if (ctl0_wr) begin
         ctl0_r <= pwdata[15:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl2_r <= `PLK_CTL2_RST;
      end else if (ctl2_wr) begin
         ctl2_r <= pwdata[15:0];
      end
   end

   // read data: palette reads as zero
   always_comb begin
      prdata = 32'h0000_0000;
      pslverr = 1'b0;
      if (psel && penable) begin
         if (!reg_hit(paddr)) begin
            pslverr = 1'b1;
         end else if (!pwrite) begin
            if (pal_hit(paddr)) begin
               prdata = 32'h0000_0000;
            end else if (ctl0_hit(paddr)) begin
               prdata = {16'h0000, ctl0_r};
            end else if (ctl2_hit(paddr)) begin
               prdata = {16'h0000, ctl2_r};
            end else begin
               prdata[`PLK_COL_W-1:0] = color_r;
               prdata[`PLK_STAT_VALID_BIT] = color_valid_r;
            end
         end
      end
   end

   // ************************************
   // mode decode
   // ************************************

   assign high_resolution_enable = ctl0_r[`PLK_HIGH_RESOLUTION_ENABLE_BIT];
   assign dual = ctl0_r[`PLK_DUAL_BIT];
   assign hold_on = ctl0_r[`PLK_HOLD_BIT];
   assign plane_cnt = ctl0_r[`PLK_CNT_HI:`PLK_CNT_LO];
   assign pf2_front = ctl2_r[`PLK_PRI_BIT];

   always_comb begin
      if (hold_on && !dual && !high_resolution_enable && hold_depth(plane_cnt)) begin
         mode = PLK_MODE_HOLD;
      end else if (dual) begin
         mode = PLK_MODE_DUAL;
      end else begin
         mode = PLK_MODE_NORMAL;
      end
   end

   // planes beyond the active count read as zero
   generate
      for (genvar g = 0; g < `PLK_PLANES; g++) begin : g_mask
         assign plane_mask[g] = (3'(g) < plane_cnt);
      end
   endgenerate

   assign p = plane_bits & plane_mask;

   // ************************************
   // colour selection
   // ************************************

   always_comb begin
      logic [`PLK_IDX_W-1:0] pf1_idx;
      logic [`PLK_IDX_W-1:0] pf2_idx;
      logic pf1_opaque;
      logic pf2_opaque;
      plk_hm_t hm;
      pf1_idx = `PLK_BG_IDX;
      pf2_idx = `PLK_BG_IDX;
      pf1_opaque = 1'b0;
      pf2_opaque = 1'b0;
      hm = plk_hm_t'(p[5:4]);
      color_nxt = color_r;
      case (mode)
         PLK_MODE_HOLD: begin
            case (hm)
               PLK_HM_PALETTE: begin
                  color_nxt = pal_r[{1'b0, p[3:0]}];
               end
               PLK_HM_BLUE: begin
                  color_nxt = hold_modify(color_r, p[3:0], hm);
               end
               PLK_HM_RED: begin
                  color_nxt = hold_modify(color_r, p[3:0], hm);
               end
               PLK_HM_GREEN: begin
                  color_nxt = hold_modify(color_r, p[3:0], hm);
               end
               default: begin
                  color_nxt = color_r;
               end
            endcase
         end
         PLK_MODE_DUAL: begin
            if (high_resolution_enable) begin
               pf1_idx = {3'b000, hi_pf1(p)};
               pf2_idx = `PLK_PF2_BASE | {3'b000, hi_pf2(p)};
               pf1_opaque = |hi_pf1(p);
               pf2_opaque = |hi_pf2(p);
            end else begin
               pf1_idx = {2'b00, lo_pf1(p)};
               pf2_idx = `PLK_PF2_BASE | {2'b00, lo_pf2(p)};
               pf1_opaque = |lo_pf1(p);
               pf2_opaque = |lo_pf2(p);
            end
            if (pf2_opaque && (pf2_front || !pf1_opaque)) begin
               color_nxt = pal_r[pf2_idx];
            end else if (pf1_opaque) begin
               color_nxt = pal_r[pf1_idx];
            end else begin
               color_nxt = pal_r[`PLK_BG_IDX];
            end
         end
         PLK_MODE_NORMAL: begin
            if (high_resolution_enable) begin
               color_nxt = pal_r[{1'b0, p[3:0]}];
            end else begin
               color_nxt = pal_r[p[4:0]];
            end
         end
         default: begin
            color_nxt = pal_r[`PLK_BG_IDX];
         end
      endcase
   end

   // ************************************
   // pixel output register
   // ************************************

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         color_r <= `PLK_COL_RST;
      end else if (pixel_valid) begin
         color_r <= color_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         color_valid_r <= 1'b0;
      end else begin
         color_valid_r <= pixel_valid;
      end
   end

   assign pixel_color = color_r;
   assign pixel_color_valid = color_valid_r;
   assign active_mode = mode;

endmodule // plk_color_lookup

`default_nettype wire

// ---- tb/plk_color_lookup_asserts.sv ----
// concurrent checks on the colour lookup ports
`include "plk_defines.svh"
`default_nettype none
module plk_color_lookup_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`PLK_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic [`PLK_PLANES-1:0] plane_bits,
   input wire logic pixel_valid,
   input wire logic [`PLK_COL_W-1:0] pixel_color,
   input wire logic pixel_color_valid,
   input wire plk_pkg::plk_mode_t active_mode
);
   import plk_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [2:0] depth_r;
   // shadow of the plane count, sixth plane masked below six
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         depth_r <= 3'h0;
      end else if (psel && penable && pwrite && paddr == `PLK_CTL0_OFS) begin
         depth_r <= pwdata[`PLK_CNT_HI:`PLK_CNT_LO];
      end
   end
   sequence s_hm(logic [1:0] c);
      pixel_valid && active_mode == PLK_MODE_HOLD &&
         {plane_bits[5] && depth_r == `PLK_CNT_SIX, plane_bits[4]} == c;
   endsequence
   a_valid_next: assert property (pixel_valid |=> pixel_color_valid)
      else $error("no colour after pixel");
   a_idle_hold: assert property (!pixel_valid |=> !pixel_color_valid && $stable(pixel_color))
      else $error("colour moved in gap");
   a_pal_wo: assert property (psel && penable && !pwrite && paddr <= 12'h07c |-> prdata == 32'h0)
      else $error("palette read back");
   a_hm_blue: assert property (s_hm(2'b01) |=> pixel_color == {$past(pixel_color[11:4]), $past(plane_bits[3:0])})
      else $error("blue modify wrong");
   a_hm_red: assert property (s_hm(2'b10) |=> pixel_color == {$past(plane_bits[3:0]), $past(pixel_color[7:0])})
      else $error("red modify wrong");
   a_hm_green: assert property (s_hm(2'b11) |=>
      pixel_color == {$past(pixel_color[11:8]), $past(plane_bits[3:0]), $past(pixel_color[3:0])})
      else $error("green modify wrong");
   a_hm_chain: assert property (s_hm(2'b01) ##2 s_hm(2'b10) |=> pixel_color[7:4] == $past(pixel_color[7:4], 3))
      else $error("green lost in chain");
   a_dual_mode: assert property (pixel_valid && active_mode == PLK_MODE_DUAL |=> pixel_color_valid)
      else $error("dual pixel dropped");
endmodule // plk_color_lookup_asserts
bind plk_color_lookup plk_color_lookup_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .plane_bits, .pixel_valid, .pixel_color, .pixel_color_valid, .active_mode);
`default_nettype wire

// ---- tb/plk_pixel_source.sv ----
// bit-plane shifter model feeding one pixel at a time
`default_nettype none
module plk_pixel_source (
   input wire logic pclk,
   output logic [5:0] plane_bits,
   output logic pixel_valid
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      pixel_valid = 1'b0;
      plane_bits = 6'h2a;
   end
   // idle bits are scrambled, never the last pixel
   task automatic send(input logic [5:0] p);
      @(posedge pclk);
      pixel_valid <= 1'b1;
      plane_bits <= p;
      @(posedge pclk);
      pixel_valid <= 1'b0;
      plane_bits <= ~p;
   endtask
endmodule // plk_pixel_source
`default_nettype wire

// ---- tb/test_plk_color_lookup.sv ----
// self-checking bench for the playfield colour lookup
`default_nettype none
module test_plk_color_lookup;
   timeunit 1ns;
   timeprecision 1ns;
   import plk_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pixel_valid, pixel_color_valid, er;
   logic [11:0] paddr, pixel_color, hc;
   logic [31:0] pwdata, prdata, rd;
   logic [5:0] plane_bits;
   plk_mode_t active_mode;
   int n_mismatch = 0;
   int tests_run = 0;
   plk_color_lookup u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .plane_bits, .pixel_valid, .pixel_color, .pixel_color_valid, .active_mode);
   plk_pixel_source u_src (.pclk, .plane_bits, .pixel_valid);
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // ****************************************
   // helpers
   // ****************************************
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask
   task automatic px(input logic [5:0] p, input logic [11:0] e);
      u_src.send(p);
      #1;
      chk(pixel_color, e);
   endtask
   function automatic logic [11:0] pal(int i);
      return 12'(i * 12'h111 + 12'h123);
   endfunction
   function automatic logic [5:0] dp(logic [2:0] f1, logic [2:0] f2);
      return {f2[2], f1[2], f2[1], f1[1], f2[0], f1[0]};
   endfunction
   task automatic test_done;
      if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_regs;
      for (int i = 0; i < 32; i++) apb(1'b1, 12'(4 * i), 32'hffff_f000 | pal(i));
      apb(1'b0, 12'h014, 32'h0);
      chk(rd, 32'h0);
      chk(er, 1'b0);
      apb(1'b0, 12'h200, 32'h0);
      chk(er, 1'b1);
   endtask
   task automatic t_low;
      apb(1'b1, 12'h100, 32'h5000);
      apb(1'b0, 12'h100, 32'h0);
      chk(rd, 32'h5000);
      for (int i = 0; i < 32; i++) px({1'b1, 5'(i)}, pal(i));
   endtask
   task automatic t_dual;
      apb(1'b1, 12'h100, 32'h6400);
      chk(active_mode, PLK_MODE_DUAL);
      px(dp(3, 0), pal(3));
      px(dp(0, 5), pal(13));
      px(dp(0, 0), pal(0));
      px(dp(6, 2), pal(6));
      apb(1'b1, 12'h104, 32'h0040);
      px(dp(6, 2), pal(10));
      px(dp(7, 0), pal(7));
   endtask
   task automatic t_high_resolution_enable;
      apb(1'b1, 12'h100, 32'hc000);
      px(6'h3a, pal(10));
      apb(1'b1, 12'h100, 32'hc400);
      px(6'h04, pal(2));
      px(6'h0a, pal(11));
      px(6'h00, pal(0));
   endtask
   task automatic t_ham;
      apb(1'b1, 12'h100, 32'h6800);
      chk(active_mode, PLK_MODE_HOLD);
      hc = pal(5);
      px(6'h05, hc);
      hc[3:0] = 4'ha;
      px(6'h1a, hc);
      hc[11:8] = 4'h3;
      px(6'h23, hc);
      hc[7:4] = 4'hc;
      px(6'h3c, hc);
      apb(1'b1, 12'h100, 32'h5800);
      hc[3:0] = 4'h5;
      px(6'h35, hc);
      apb(1'b1, 12'h100, 32'he800);
      chk(active_mode, PLK_MODE_NORMAL);
      px(6'h1a, pal(10));
      apb(1'b1, 12'h100, 32'h6c00);
      chk(active_mode, PLK_MODE_DUAL);
   endtask
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_low;
      t_dual;
      t_high_resolution_enable;
      t_ham;
      test_done;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      test_done;
   end
endmodule // test_plk_color_lookup
`default_nettype wire
